/* logic/mmi_device.sv */
/*
 * device end of the serial management port: frame decoder, 32 direct
 * registers and the indirect window into an extended register set.
 * assumes mdc and mdio are asynchronous and slower than a quarter of clk.
 */
// Summary of operation
// - mdc at most 25 MHz, may stop
// - receivers sample mdio on mdc rise
// - line released when idle or first read turnaround bit
// - bus address caught from straps after reset
// - station waits one mdc after reset (mmi_station has no such wait; the bench waits 20 clk before the first frame)
// - direct frames reach 32 registers
// - frame starts with zero then one
// - read turnaround: release, then zero, data
// - write turnaround driven one zero by station
// - window registers not reachable indirectly
// - only device select all ones accepted
// - function 00 reaches the pointer
// - function 01 accesses, pointer unchanged
// - function 10 increments after any access
// - function 11 increments after writes only
// - station loads pointer before extended access
// - pointer set via 001f then address
// - address function rewrites pointer each write
// - standard registers reachable indirectly too
module mmi_device
   import mmi_pkg::*;
#(
   parameter int EXT_WORDS = 32
) (
   input  wire logic               clk,
   input  wire logic               rstn,
   input  wire logic [STRAP_W-1:0] straps,
   output logic      [STRAP_W-1:0] bus_address,
   mmi_if.device                   link
);
   // ********
   // state
   // ********
   localparam int EXT_AW = (EXT_WORDS > 1) ? $clog2(EXT_WORDS) : 1;

   typedef enum logic [2:0] {
      D_IDLE  = 3'h0,
      D_START = 3'h1,
      D_HDR   = 3'h3,
      D_TA    = 3'h2,
      D_DATA  = 3'h6
   } mmi_dev_st_e;

   typedef struct packed {
      logic [2:0]                       mdc_sync;
      logic [1:0]                       mdio_sync;
      logic [1:0][STRAP_W-1:0]          strap_sync;
      logic [1:0]                       strap_wait;
      logic                             strap_done;
      logic [STRAP_W-1:0]               addr;
      mmi_dev_st_e                      st;
      logic [3:0]                       cnt;
      logic [HDR_BITS-1:0]              hdr;
      logic [DATA_W-1:0]                sh;
      logic                             hit;
      logic                             hit_rd;
      logic                             drv_o;
      logic                             drv_oe;
      logic [NUM_REGS-1:0][DATA_W-1:0]  regs;
      logic [DATA_W-1:0]                ptr;
      logic [EXT_WORDS-1:0][DATA_W-1:0] ext;
   } mmi_dev_s;

   mmi_dev_s          s_ff;
   mmi_dev_s          nxt_s;
   logic              rise;
   logic              bitv;
   logic              last;
   logic [1:0]        op;
   logic              hit_now;
   logic [HDR_BITS-1:0] nh;
   logic [DATA_W-1:0] w;
   logic [REG_W-1:0]  a;

   // ********
   // window helpers
   // ********
   function automatic logic [1:0] fn_of(input mmi_dev_s s);
      return s.regs[REG_ACC_CTRL][FN_LO +: 2];
   endfunction

   // other device selects make the window inert
   function automatic logic win_ok(input mmi_dev_s s);
      return s.regs[REG_ACC_CTRL][DEVSEL_HI:0] == DEVSEL_MMD;
   endfunction

   function automatic logic is_win_reg(input logic [REG_W-1:0] r);
      return (r == REG_ACC_CTRL) || (r == REG_WINDOW);
   endfunction

   function automatic logic ext_hit(input logic [DATA_W-1:0] p);
      logic [DATA_W-1:0] off;
      off = p - EXT_BASE;
      return (p >= EXT_BASE) && (off < DATA_W'(EXT_WORDS));
   endfunction

   function automatic logic [EXT_AW-1:0] ext_idx(input logic [DATA_W-1:0] p);
      logic [DATA_W-1:0] off;
      off = p - EXT_BASE;
      return off[EXT_AW-1:0];
   endfunction

   // pointer below the extended base aliases the standard registers
   function automatic logic [DATA_W-1:0] ind_rd(input mmi_dev_s s);
      logic [DATA_W-1:0] v;
      v = '0;
      if (s.ptr < EXT_BASE) begin
         if (!is_win_reg(s.ptr[REG_W-1:0])) begin
            v = s.regs[s.ptr[REG_W-1:0]];
         end
      end else if (ext_hit(s.ptr)) begin
         v = s.ext[ext_idx(s.ptr)];
      end
      return v;
   endfunction

   function automatic logic [DATA_W-1:0] rd_val(input mmi_dev_s s, input logic [REG_W-1:0] r);
      logic [DATA_W-1:0] v;
      v = s.regs[r];
      if (r == REG_WINDOW) begin
         if (!win_ok(s)) begin
            v = '0;
         end else if (fn_of(s) == FN_ADDR) begin
            v = s.ptr;
         end else begin
            v = ind_rd(s);
         end
      end
      return v;
   endfunction

   // ********
   // next state
   // ********
   // mdc and mdio share the same synchroniser depth so a bit is seen
   // with the edge it belongs to; a stopped mdc simply freezes the frame
   always_comb begin
      nxt_s   = s_ff;
      hit_now = 1'b0;
      nh      = '0;
      op      = '0;
      w       = '0;
      a       = '0;
      nxt_s.mdc_sync   = {s_ff.mdc_sync[1:0], link.mdc};
      nxt_s.mdio_sync  = {s_ff.mdio_sync[0], link.mdio};
      nxt_s.strap_sync = {s_ff.strap_sync[0], straps};
      rise = s_ff.mdc_sync[1] & ~s_ff.mdc_sync[2];
      bitv = s_ff.mdio_sync[1];
      last = s_ff.cnt == 4'(DATA_W - 1);

      // address taken once, after the strap synchroniser has filled
      if (!s_ff.strap_done) begin
         if (s_ff.strap_wait == STRAP_SETTLE) begin
            nxt_s.addr       = s_ff.strap_sync[1];
            nxt_s.strap_done = 1'b1;
         end else begin
            nxt_s.strap_wait = s_ff.strap_wait + 2'h1;
         end
      end

      if (rise) begin
         unique case (s_ff.st)
            D_IDLE: begin
               if (!bitv) begin
                  nxt_s.st = D_START;
               end
            end
            D_START: begin
               if (bitv) begin
                  nxt_s.st  = D_HDR;
                  nxt_s.cnt = '0;
               end
            end
            D_HDR: begin
               nh        = {s_ff.hdr[HDR_BITS-2:0], bitv};
               nxt_s.hdr = nh;
               nxt_s.cnt = s_ff.cnt + 4'h1;
               if (s_ff.cnt == 4'(HDR_BITS - 1)) begin
                  op      = nh[HDR_OP_LO +: 2];
                  hit_now = s_ff.strap_done && (op == OP_READ || op == OP_WRITE) &&
                            nh[HDR_PHY_LO +: PHY_W] ==
                            {{(PHY_W - STRAP_W){1'b0}}, s_ff.addr};
                  nxt_s.hit    = hit_now;
                  nxt_s.hit_rd = hit_now && (op == OP_READ);
                  nxt_s.cnt    = '0;
                  nxt_s.st     = (op == OP_READ || op == OP_WRITE) ? D_TA : D_IDLE;
                  if (hit_now && op == OP_READ) begin
                     nxt_s.sh = rd_val(s_ff, nh[REG_W-1:0]);
                     if (nh[REG_W-1:0] == REG_WINDOW && win_ok(s_ff) &&
                         fn_of(s_ff) == FN_INC_RW) begin
                        nxt_s.ptr = s_ff.ptr + 16'h1;
                     end
                  end
               end
            end
            D_TA: begin
               nxt_s.cnt = s_ff.cnt + 4'h1;
               if (s_ff.cnt == 4'h0) begin
                  // first turnaround bit stays released, zero goes out next
                  nxt_s.drv_oe = s_ff.hit_rd;
                  nxt_s.drv_o  = 1'b0;
               end else begin
                  nxt_s.st  = D_DATA;
                  nxt_s.cnt = '0;
                  if (s_ff.hit_rd) begin
                     nxt_s.drv_o = s_ff.sh[DATA_W-1];
                     nxt_s.sh    = {s_ff.sh[DATA_W-2:0], 1'b0};
                  end
               end
            end
            D_DATA: begin
               nxt_s.cnt = s_ff.cnt + 4'h1;
               if (s_ff.hit_rd) begin
                  nxt_s.drv_o  = last ? 1'b0 : s_ff.sh[DATA_W-1];
                  nxt_s.drv_oe = !last;
                  nxt_s.sh     = {s_ff.sh[DATA_W-2:0], 1'b0};
               end else begin
                  nxt_s.sh = {s_ff.sh[DATA_W-2:0], bitv};
               end
               if (last) begin
                  nxt_s.st = D_IDLE;
                  w = {s_ff.sh[DATA_W-2:0], bitv};
                  a = s_ff.hdr[REG_W-1:0];
                  if (s_ff.hit && !s_ff.hit_rd) begin
                     if (a != REG_WINDOW) begin
                        nxt_s.regs[a] = w;
                     end else if (win_ok(s_ff)) begin
                        if (fn_of(s_ff) == FN_ADDR) begin
                           nxt_s.ptr = w;
                        end else begin
                           if (s_ff.ptr < EXT_BASE) begin
                              if (!is_win_reg(s_ff.ptr[REG_W-1:0])) begin
                                 nxt_s.regs[s_ff.ptr[REG_W-1:0]] = w;
                              end
                           end else if (ext_hit(s_ff.ptr)) begin
                              nxt_s.ext[ext_idx(s_ff.ptr)] = w;
                           end
                           if (fn_of(s_ff) == FN_INC_RW || fn_of(s_ff) == FN_INC_WR) begin
                              nxt_s.ptr = s_ff.ptr + 16'h1;
                           end
                        end
                     end
                  end
               end
            end
         endcase
      end
   end

   // ********
   // registers and outputs
   // ********
   // reset releases the line at once and forgets any frame in flight
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign link.dev_o   = s_ff.drv_o;
   assign link.dev_oe  = s_ff.drv_oe;
   assign bus_address  = s_ff.addr;
endmodule // mmi_device

/* logic/mmi_pkg.sv */
/*
 * shared constants of the serial management port: frame layout, register
 * offsets of the indirect window, function codes and controller map.
 * assumes a 100 MHz system clock on both ends.
 */
package mmi_pkg;
   // ********
   // timing
   // ********
   localparam int CLK_HZ       = 100_000_000;
   localparam int MDC_MAX_HZ   = 25_000_000;
   // shortest legal half period of the management clock, rounded up
   localparam int MDC_HALF_MIN = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);

   // ********
   // frame layout
   // ********
   localparam int STRAP_W    = 4;
   localparam int PHY_W      = 5;
   localparam int REG_W      = 5;
   localparam int DATA_W     = 16;
   localparam int HDR_BITS   = 12;
   localparam int HDR_OP_LO  = 10;
   localparam int HDR_PHY_LO = 5;
   localparam int NUM_REGS   = 32;
   localparam int DRIVE_BITS = 14;
   localparam int DATA_FIRST = 16;
   localparam int FRAME_BITS = 32;
   localparam logic [1:0] START_PAT = 2'h1;
   localparam logic [1:0] OP_READ   = 2'h2;
   localparam logic [1:0] OP_WRITE  = 2'h1;
   localparam logic [1:0] TA_WRITE  = 2'h2;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // ********
   // indirect window
   // ********
   localparam logic [4:0]  REG_ACC_CTRL = 5'h0d;
   localparam logic [4:0]  REG_WINDOW   = 5'h0e;
   localparam logic [4:0]  DEVSEL_MMD   = 5'h1f;
   localparam int          DEVSEL_HI    = 4;
   localparam int          FN_LO        = 14;
   localparam logic [1:0]  FN_ADDR      = 2'h0;
   localparam logic [1:0]  FN_DATA      = 2'h1;
   localparam logic [1:0]  FN_INC_RW    = 2'h2;
   localparam logic [1:0]  FN_INC_WR    = 2'h3;
   localparam logic [15:0] EXT_BASE     = 16'h0020;

   // ********
   // controller register map
   // ********
   localparam int         APB_AW     = 8;
   localparam logic [7:0] OFF_CMD    = 8'h00;
   localparam logic [7:0] OFF_WDATA  = 8'h04;
   localparam logic [7:0] OFF_RDATA  = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam int CMD_GO     = 0;
   localparam int CMD_RD     = 1;
   localparam int CMD_PHY_LO = 4;
   localparam int CMD_REG_LO = 12;
   localparam int STAT_BUSY  = 0;
   localparam int STAT_DONE  = 1;
endpackage

/* logic/mmi_if.sv */
/*
 * the management link between station and device.
 * assumes the bench reads mdio as the resolved wire with its pull-up.
 */
interface mmi_if;
   logic mdc;
   logic sta_o;
   logic sta_oe;
   logic dev_o;
   logic dev_oe;
   logic mdio;

   // resolved wire: an undriven line floats high through the pull-up
   assign mdio = sta_oe ? sta_o : (dev_oe ? dev_o : 1'b1);

   modport station (output mdc, output sta_o, output sta_oe, input mdio);
   modport device  (input mdc, input mdio, output dev_o, output dev_oe);
endinterface

/* logic/mmi_station.sv */
/*
 * station end: an apb slave takes one management command at a time and
 * runs it as a clause 22 frame on the link, making mdc by a divider.
 * assumes one clk domain for apb and the divider.
 */
module mmi_station
   import mmi_pkg::*;
#(
   parameter int MDC_HALF = 8,
   parameter int PRE_BITS = 32
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   mmi_if.station                 link
);
   // ********
   // state
   // ********
   typedef enum logic [1:0] {S_IDLE = 2'h0, S_RUN = 2'h1, S_TAIL = 2'h3} mmi_sta_st_e;

   typedef struct packed {
      mmi_sta_st_e       st;
      logic [7:0]        div;
      logic [6:0]        bcnt;
      logic              mdc;
      logic              o;
      logic              oe;
      logic [31:0]       frame;
      logic              is_rd;
      logic [PHY_W-1:0]  phy;
      logic [REG_W-1:0]  ra;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic              done;
      logic [1:0]        mdio_sync;
      logic [31:0]       prdata;
      logic              pslverr;
   } mmi_sta_s;

   localparam logic [6:0] LAST_BIT = 7'(PRE_BITS + FRAME_BITS - 1);
   localparam logic [7:0] HALF_END = 8'(MDC_HALF - 1);

   mmi_sta_s s_ff;
   mmi_sta_s nxt_s;
   logic     tick;
   logic     wr_acc;

   // drive pattern of bit i: preamble ones, then the frame msb first,
   // released from the turnaround on when reading
   function automatic logic [1:0] bit_of(input mmi_sta_s s, input logic [6:0] i);
      logic [6:0] j;
      j = i - 7'(PRE_BITS);
      if (i < 7'(PRE_BITS)) begin
         return 2'h3;
      end
      return {!s.is_rd || j < 7'(DRIVE_BITS), s.frame[5'(FRAME_BITS - 1) - j[4:0]]};
   endfunction

   // ********
   // next state
   // ********
   always_comb begin
      nxt_s = s_ff;
      nxt_s.mdio_sync = {s_ff.mdio_sync[0], link.mdio};
      tick   = s_ff.div == HALF_END;
      wr_acc = psel & penable & pwrite;

      // read data latched at setup so prdata comes from a flop
      if (psel && !penable) begin
         nxt_s.pslverr = 1'b0;
         nxt_s.prdata  = '0;
         unique case (paddr)
            OFF_CMD: begin
               nxt_s.prdata[CMD_RD]                 = s_ff.is_rd;
               nxt_s.prdata[CMD_PHY_LO +: PHY_W]    = s_ff.phy;
               nxt_s.prdata[CMD_REG_LO +: REG_W]    = s_ff.ra;
            end
            OFF_WDATA:  nxt_s.prdata[DATA_W-1:0]    = s_ff.wdata;
            OFF_RDATA:  nxt_s.prdata[DATA_W-1:0]    = s_ff.rdata;
            OFF_STATUS: begin
               nxt_s.prdata[STAT_BUSY] = s_ff.st != S_IDLE;
               nxt_s.prdata[STAT_DONE] = s_ff.done;
            end
            default: nxt_s.pslverr = 1'b1;
         endcase
      end

      if (s_ff.st != S_IDLE) begin
         nxt_s.div = tick ? 8'h00 : s_ff.div + 8'h01;
      end
      if (tick) begin
         unique case (s_ff.st)
            S_IDLE: ;
            S_RUN: begin
               nxt_s.mdc = !s_ff.mdc;
               if (!s_ff.mdc) begin
                  if (s_ff.is_rd && s_ff.bcnt >= 7'(PRE_BITS + DATA_FIRST)) begin
                     nxt_s.rdata = {s_ff.rdata[DATA_W-2:0], s_ff.mdio_sync[1]};
                  end
               end else if (s_ff.bcnt == LAST_BIT) begin
                  nxt_s.oe = 1'b0;
                  nxt_s.o  = 1'b0;
                  nxt_s.st = S_TAIL;
               end else begin
                  nxt_s.bcnt = s_ff.bcnt + 7'h01;
                  {nxt_s.oe, nxt_s.o} = bit_of(s_ff, s_ff.bcnt + 7'h01);
               end
            end
            S_TAIL: begin
               // one released mdc cycle keeps the bus idle between frames
               nxt_s.mdc = !s_ff.mdc;
               if (s_ff.mdc) begin
                  nxt_s.st   = S_IDLE;
                  nxt_s.done = 1'b1;
               end
            end
            default: nxt_s.st = S_IDLE;
         endcase
      end

      // register writes land at the access edge; done set wins over clear
      if (wr_acc) begin
         if (paddr == OFF_WDATA) begin
            nxt_s.wdata = pwdata[DATA_W-1:0];
         end
         if (paddr == OFF_STATUS && pwdata[STAT_DONE] &&
             !(tick && s_ff.st == S_TAIL && s_ff.mdc)) begin
            nxt_s.done = 1'b0;
         end
         if (paddr == OFF_CMD && s_ff.st == S_IDLE) begin
            nxt_s.is_rd = pwdata[CMD_RD];
            nxt_s.phy   = pwdata[CMD_PHY_LO +: PHY_W];
            nxt_s.ra    = pwdata[CMD_REG_LO +: REG_W];
            if (pwdata[CMD_GO]) begin
               nxt_s.frame = {START_PAT, pwdata[CMD_RD] ? OP_READ : OP_WRITE,
                              pwdata[CMD_PHY_LO +: PHY_W], pwdata[CMD_REG_LO +: REG_W],
                              TA_WRITE, s_ff.wdata};
               nxt_s.st   = S_RUN;
               nxt_s.div  = '0;
               nxt_s.bcnt = '0;
               nxt_s.mdc  = 1'b0;
               nxt_s.o    = 1'b1;
               nxt_s.oe   = 1'b1;
            end
         end
      end
   end

   // ********
   // registers and outputs
   // ********
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign link.mdc    = s_ff.mdc;
   assign link.sta_o  = s_ff.o;
   assign link.sta_oe = s_ff.oe;
   assign prdata      = s_ff.prdata;
   assign pslverr     = s_ff.pslverr;
   assign pready      = psel & penable;
endmodule // mmi_station

/* bench/mmi_checker.sv */
/*
 * link checker: concurrent properties on the management wire between the
 * station and the device.
 * assumes one clk domain and the signals of mmi_if handed in as plain inputs.
 */
module mmi_checker
   import mmi_pkg::*;
#(
   parameter int MDC_HALF = 8,
   parameter int PRE_BITS = 32
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic mdc,
   input wire logic sta_o,
   input wire logic sta_oe,
   input wire logic dev_o,
   input wire logic dev_oe,
   input wire logic mdio
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************
   // helper counters
   // ****************
   logic       mdc_ff;
   logic       soe_ff;
   logic [7:0] run_ff;
   logic [6:0] bit_ff;
   logic [4:0] dbit_ff;

   // run_ff saturates so that a long idle stretch cannot wrap into a short one
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mdc_ff  <= 1'b0;
         soe_ff  <= 1'b0;
         run_ff  <= 8'h0;
         bit_ff  <= 7'h0;
         dbit_ff <= 5'h0;
      end else begin
         mdc_ff  <= mdc;
         soe_ff  <= sta_oe;
         run_ff  <= (mdc != mdc_ff) ? 8'h1 : ((run_ff == 8'hff) ? run_ff : run_ff + 8'h1);
         bit_ff  <= (sta_oe && !soe_ff) ? 7'h0 : bit_ff + 7'(mdc && !mdc_ff);
         dbit_ff <= !dev_oe ? 5'h0 : dbit_ff + 5'(mdc && !mdc_ff);
      end
   end

   // ****************
   // properties
   // ****************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   chk_mdc_high_time: assert property ($fell(mdc) |-> run_ff == 8'(MDC_HALF))
      else $error("mdc high phase has the wrong length");
   chk_mdc_low_time: assert property ($rose(mdc) |-> run_ff >= 8'(MDC_HALF))
      else $error("mdc low phase too short");
   chk_no_contention: assert property (!(sta_oe && dev_oe))
      else $error("both ends drive the data line");
   chk_frame_open: assert property ($rose(sta_oe) |-> sta_o && !mdc)
      else $error("frame does not open from idle");
   chk_start_bits: assert property ($rose(mdc) && sta_oe && bit_ff == 7'(PRE_BITS)
      |-> !sta_o ##[1:20] ($rose(mdc) && sta_oe && sta_o))
      else $error("start pattern wrong");
   chk_write_ta: assert property ($rose(mdc) && sta_oe && bit_ff == 7'(PRE_BITS + 14)
      |-> sta_o ##[1:20] ($rose(mdc) && sta_oe && !sta_o))
      else $error("write turnaround wrong");
   chk_sta_setup: assert property (sta_oe && $rose(mdc) |-> $stable(sta_o))
      else $error("station data moves at mdc rise");
   chk_dev_setup: assert property (dev_oe && $rose(mdc) |-> $stable(dev_o))
      else $error("device data moves at mdc rise");
   chk_dev_ta_zero: assert property ($rose(dev_oe) |-> !dev_o)
      else $error("device turnaround bit not zero");
   chk_dev_bit_count: assert property ($fell(dev_oe) |-> dbit_ff == 5'h11)
      else $error("device drove the wrong number of bits");
   chk_ta_release: assert property ($fell(sta_oe) |-> (!dev_oe)[*8])
      else $error("device drives during released bit");
   chk_ta_free: assert property ($rose(mdc) && !sta_oe && bit_ff == 7'(PRE_BITS + 14)
      |-> mdio)
      else $error("first read turnaround bit not left to the pull-up");

   cover property ($fell(dev_oe));
   cover property ($rose(mdc) && sta_oe && bit_ff == 7'(PRE_BITS + 14));
   cover property ($fell(sta_oe) && !dev_oe);
endmodule // mmi_checker

/* bench/mdio_mgmt_with_mmd_indirect_tb.sv */
/*
 * self-checking bench: station and device joined by the link, the station
 * driven over apb, table of frames then hand-written odd cases.
 * assumes the pull-up of the data line is resolved inside mmi_if.
 */
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module mdio_mgmt_with_mmd_indirect_tb
   import mmi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************
   // set-up
   // ****************
   localparam int   MDC_H = 8;
   localparam int   PRE   = 4;
   localparam logic W     = 1'b0;
   localparam logic R     = 1'b1;
   typedef struct packed {logic rd; logic [4:0] rg; logic [15:0] d;} mmi_row_s;
   // frames in order, all to bus address 5; d is write data or expected read data
   localparam mmi_row_s ROWS [46] = '{
      '{W,5'h02,16'h1234}, '{R,5'h02,16'h1234}, '{W,5'h1f,16'ha5c3}, '{R,5'h1f,16'ha5c3},
      '{W,5'h0d,16'h001f}, '{W,5'h0e,16'h0020}, '{R,5'h0e,16'h0020}, '{W,5'h0e,16'h0021},
      '{R,5'h0e,16'h0021}, '{W,5'h0d,16'h401f}, '{W,5'h0e,16'hbeef}, '{R,5'h0e,16'hbeef},
      '{R,5'h0e,16'hbeef}, '{W,5'h0d,16'h001f}, '{W,5'h0e,16'h0002}, '{W,5'h0d,16'h401f},
      '{R,5'h0e,16'h1234}, '{W,5'h0d,16'h001f}, '{W,5'h0e,16'h0030}, '{W,5'h0d,16'h801f},
      '{W,5'h0e,16'h1111}, '{W,5'h0e,16'h2222}, '{W,5'h0d,16'h001f}, '{R,5'h0e,16'h0032},
      '{W,5'h0e,16'h0030}, '{W,5'h0d,16'hc01f}, '{R,5'h0e,16'h1111}, '{R,5'h0e,16'h1111},
      '{W,5'h0e,16'h3333}, '{R,5'h0e,16'h2222}, '{W,5'h0d,16'h001f}, '{W,5'h0e,16'h0030},
      '{W,5'h0d,16'h801f}, '{R,5'h0e,16'h3333}, '{R,5'h0e,16'h2222}, '{W,5'h0d,16'h001f},
      '{W,5'h0e,16'h000d}, '{W,5'h0d,16'h401f}, '{R,5'h0e,16'h0000}, '{W,5'h0e,16'h7777},
      '{R,5'h0d,16'h401f}, '{W,5'h0d,16'h001e}, '{W,5'h0e,16'h0005}, '{R,5'h0e,16'h0000},
      '{W,5'h0d,16'h001f}, '{R,5'h0e,16'h000d}};

   logic        clk, rstn, psel, penable, pwrite, pslverr, pready, e;
   logic [3:0]  straps, bus_address;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, d;
   logic [32:0] sh_ff;
   logic [15:0] q;
   int          err_total, total_checks, cyc;

   mmi_if link ();
   mmi_station #(.MDC_HALF(MDC_H), .PRE_BITS(PRE)) u_mmi_station (.clk(clk), .rstn(rstn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   mmi_device #(.EXT_WORDS(32)) u_mmi_device (.clk(clk), .rstn(rstn), .straps(straps),
      .bus_address(bus_address), .link(link));
   mmi_checker #(.MDC_HALF(MDC_H), .PRE_BITS(PRE)) u_mmi_checker (.clk(clk), .rstn(rstn),
      .mdc(link.mdc), .sta_o(link.sta_o), .sta_oe(link.sta_oe), .dev_o(link.dev_o),
      .dev_oe(link.dev_oe), .mdio(link.mdio));

   initial clk = 1'b0;
   always #5 clk = ~clk;

   // what the wire carried, in the order the receivers sampled it
   always @(posedge link.mdc) sh_ff <= {sh_ff[31:0], link.mdio};

   // hang guard, well above the roughly 31500 cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // ****************
   // tasks
   // ****************
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // one apb transfer, held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   function automatic logic [31:0] cmd(logic rd, logic [4:0] phy, logic [4:0] rg);
      return (32'(rg) << CMD_REG_LO) | (32'(phy) << CMD_PHY_LO) | (32'(rd) << CMD_RD) | 32'h1;
   endfunction

   task automatic wait_idle;
      logic [31:0] s;
      logic        x;
      s = 32'h1;
      while (s[STAT_BUSY] !== 1'b0) apb(1'b0, OFF_STATUS, 32'h0, s, x);
   endtask

   // a whole management frame; read data lands in q
   task automatic frame(input logic rd, input logic [4:0] phy, rg, input logic [15:0] wd);
      logic [31:0] r;
      logic        x;
      if (!rd) apb(1'b1, OFF_WDATA, {16'h0, wd}, r, x);
      apb(1'b1, OFF_CMD, cmd(rd, phy, rg), r, x);
      wait_idle();
      apb(1'b0, OFF_RDATA, 32'h0, r, x);
      q = r[15:0];
   endtask

   task automatic wire_chk(input logic rd, input logic [4:0] phy, rg, input logic [1:0] ta,
                           input logic [15:0] v);
      `CHK(sh_ff[32:1], {2'b01, rd ? 2'b10 : 2'b01, phy, rg, ta, v})
   endtask

   // ****************
   // main sequence
   // ****************
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      straps = 4'h5;
      err_total = 0;
      total_checks = 0;
      cyc = 0;
      repeat (16) @(posedge clk);
      `CHK(bus_address, 4'h0)
      `CHK({link.mdc, link.sta_oe, link.dev_oe}, 3'h0)
      rstn <= 1'b1;
      // bus left quiet for longer than one mdc cycle after release
      repeat (20) @(posedge clk);
      `CHK(bus_address, 4'h5)
      $display("end of test: reset");
      foreach (ROWS[i]) begin
         frame(ROWS[i].rd, 5'h05, ROWS[i].rg, ROWS[i].d);
         if (ROWS[i].rd) `CHK(q, ROWS[i].d)
         wire_chk(ROWS[i].rd, 5'h05, ROWS[i].rg, 2'b10, ROWS[i].d);
      end
      $display("end of test: table of frames");
      // another bus address: nobody answers and the pull-up shows through
      frame(W, 5'h06, 5'h02, 16'h0bad);
      frame(R, 5'h06, 5'h02, 16'h0);
      `CHK(q, 16'hffff)
      wire_chk(R, 5'h06, 5'h02, 2'b11, 16'hffff);
      frame(R, 5'h05, 5'h02, 16'h0);
      `CHK(q, 16'h1234)
      // a command given while busy is dropped whole
      apb(1'b1, OFF_WDATA, 32'h0000abcd, d, e);
      apb(1'b1, OFF_CMD, cmd(W, 5'h05, 5'h03), d, e);
      apb(1'b1, OFF_CMD, cmd(W, 5'h05, 5'h04), d, e);
      wait_idle();
      frame(R, 5'h05, 5'h04, 16'h0);
      `CHK(q, 16'h0000)
      frame(R, 5'h05, 5'h03, 16'h0);
      `CHK(q, 16'habcd)
      apb(1'b0, OFF_CMD, 32'h0, d, e);
      `CHK(d, 32'h00003052)
      $display("end of test: address match and busy");
      // done flag is sticky and cleared by writing one; unmapped offset errors
      apb(1'b0, OFF_STATUS, 32'h0, d, e);
      `CHK(d, 32'h2)
      apb(1'b1, OFF_STATUS, 32'h2, d, e);
      apb(1'b0, OFF_STATUS, 32'h0, d, e);
      `CHK(d, 32'h0)
      apb(1'b0, 8'h10, 32'h0, d, e);
      `CHK({e, d}, 33'h100000000)
      $display("end of test: controller registers");
      tally_and_finish();
   end
endmodule // mdio_mgmt_with_mmd_indirect_tb
